// *** core/tps_regs.sv ***
// Thermal and power management service register bank
// ==========================================================
// Functional notes
// - Log bit sets on rising edge of its thermal status bit.
// - Log bits clear only by masked status read or reset.
// - Mask zero clears matching log; mask one leaves it.
// - Zero mask bit at non-log position gives failing completion.
// - Bit 1 is the activation log; mask fffffffd clears only it.
// - Averaging constant: 2^N window, max 8, reset 4, zero off.
// - 32-bit 1 ms wrapping counter of thermally constrained time, ramp included.
// - Constrained time ignores activation caused by external throttle pin.
// - Current limit in low 13 bits, 1/8 A, reset 0x438.
// - 32-bit wrapping energy counters; parameter picks package or core.
// - Core limit off after reset; active once enable set.
// - Cores dropped below requested state only when clamp set.
// - Control time window sits in bits 23:17.
// - 64-bit package limit written as two 32-bit halves.
// - Limit 1 defaults to design power level; limit 2 none.
// - Without limit 1 enabled, package may turbo to design power level.
// - 32-bit wrapping counter of time below requested state, unit ticks.
// - Unit word resets to power 3, energy 16, time 10.
`timescale 1ns/1ps
`default_nettype none
module tps_regs #(
  parameter int unsigned MS_CYC = tps_pkg::MS_TICK_CYC,
  parameter int unsigned TU_CYC = tps_pkg::TU_TICK_CYC
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Request port from the sideband link
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire tps_pkg::tps_svc_t req_svc_i,
  input wire logic [15:0] req_param_i,
  input wire logic [31:0] req_wdata_i,
  output logic rsp_valid_o,
  output logic rsp_ok_o,
  output logic [31:0] rsp_data_o,
  // Thermal condition inputs
  input wire logic tcc_active_i,
  input wire logic tcc_ext_pin_i,
  input wire logic tcc_ramp_i,
  input wire logic throttle_pin_i,
  input wire logic crit_temp_i,
  // Power accounting inputs
  input wire logic below_os_req_i,
  input wire logic [15:0] energy_pkg_inc_i,
  input wire logic [15:0] energy_core_inc_i,
  input wire logic [14:0] design_power_level_i,
  // Control outputs
  output logic [3:0] avg_const_o,
  output logic [31:0] core_limit_o,
  output logic core_drop_allowed_o,
  output logic [63:0] pkg_limit_o,
  output logic [14:0] pkg_pl1_eff_o,
  output logic pkg_drop_allowed_o
);
  import tps_pkg::*;

  // ==========================================================
  // Helpers
  function automatic logic mask_illegal(input logic [31:0] m);
    return |(~m & ~TS_LOG_BITS);
  endfunction : mask_illegal

  // ==========================================================
  // Ticks and counters
  logic ms_tick;
  logic tu_tick;
  logic [CNT_N-1:0] cnt_en;
  logic [15:0] cnt_inc [CNT_N];
  logic [31:0] cnt_val [CNT_N];

  tps_tick #(.DIV(MS_CYC)) u_ms_tick (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .tick_o(ms_tick)
  );

  tps_tick #(.DIV(TU_CYC)) u_tu_tick (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .tick_o(tu_tick)
  );

  // Ramp-back time counts, externally forced activation does not
  assign cnt_en[CNT_TC] = ms_tick & ((tcc_active_i & ~tcc_ext_pin_i) | tcc_ramp_i);
  assign cnt_inc[CNT_TC] = 16'h0001;
  assign cnt_en[CNT_PERF] = tu_tick & below_os_req_i;
  assign cnt_inc[CNT_PERF] = 16'h0001;
  assign cnt_en[CNT_E_PKG] = 1'b1;
  assign cnt_inc[CNT_E_PKG] = energy_pkg_inc_i;
  assign cnt_en[CNT_E_CORE] = 1'b1;
  assign cnt_inc[CNT_E_CORE] = energy_core_inc_i;

  genvar gi;
  generate
    for (gi = 0; gi < CNT_N; gi++) begin : g_cnt
      tps_wrap_cnt u_cnt (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .en_i(cnt_en[gi]),
        .inc_i(cnt_inc[gi]),
        .cnt_o(cnt_val[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Request decode
  logic rd_req;
  logic wr_req;
  logic ts_rd;
  logic ts_ok;
  assign rd_req = req_valid_i & ~req_write_i;
  assign wr_req = req_valid_i & req_write_i;
  assign ts_rd = rd_req && (req_svc_i == TPS_SVC_THERM_STATUS);
  assign ts_ok = ts_rd && !mask_illegal(req_wdata_i);

  // ==========================================================
  // Thermal status and sticky logs
  logic [2:0] stat_q;
  logic [2:0] log_q;
  logic [2:0] log_d;
  logic [2:0] rise;
  logic [2:0] clr;
  logic [31:0] ts_word;

  assign rise = {crit_temp_i, throttle_pin_i, tcc_active_i} & ~stat_q;
  // Inverted mask at log positions; only honoured on a legal mask
  assign clr = ts_ok ? ~{req_wdata_i[TS_CRIT_LOG], req_wdata_i[TS_PIN_LOG],
                         req_wdata_i[TS_TCC_LOG]} : 3'b000;
  assign log_d = (log_q & ~clr) | rise;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stat_q <= 3'b000;
      log_q <= 3'b000;
    end else begin
      stat_q <= {crit_temp_i, throttle_pin_i, tcc_active_i};
      log_q <= log_d;
    end
  end

  always_comb begin
    ts_word = 32'h0;
    ts_word[TS_TCC_STAT] = stat_q[0];
    ts_word[TS_TCC_LOG] = log_q[0];
    ts_word[TS_PIN_STAT] = stat_q[1];
    ts_word[TS_PIN_LOG] = log_q[1];
    ts_word[TS_CRIT_STAT] = stat_q[2];
    ts_word[TS_CRIT_LOG] = log_q[2];
  end

  // ==========================================================
  // Writable settings
  logic [3:0] avg_q;
  logic [31:0] core_q;
  logic [31:0] pkg_lo_q;
  logic [31:0] pkg_hi_q;
  logic pl1_init_q;
  logic avg_wr_ok;

  assign avg_wr_ok = wr_req && (req_svc_i == TPS_SVC_AVG_CONST) &&
                     (req_wdata_i[31:4] == 28'h0) && (req_wdata_i[3:0] <= AVG_MAX);

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avg_q <= AVG_RESET;
    end else if (avg_wr_ok) begin
      avg_q <= req_wdata_i[3:0];
    end
  end

  // Whole word replaced: the host supplies every field each time
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_q <= PL_RESET;
    end else if (wr_req && (req_svc_i == TPS_SVC_CORE_LIMIT)) begin
      core_q <= req_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pkg_lo_q <= PL_RESET;
      pkg_hi_q <= PL_RESET;
      pl1_init_q <= 1'b0;
    end else if (wr_req && (req_svc_i == TPS_SVC_PKG_LIM_LO)) begin
      pkg_lo_q <= req_wdata_i;
      pl1_init_q <= 1'b1;
    end else if (wr_req && (req_svc_i == TPS_SVC_PKG_LIM_HI)) begin
      pkg_hi_q <= req_wdata_i;
    end
  end

  // ==========================================================
  // Limit outputs
  logic [31:0] pkg_lo_rd;
  always_comb begin
    pkg_lo_rd = pkg_lo_q;
    if (!pl1_init_q) begin
      pkg_lo_rd[PL_LIM_LSB +: PL_LIM_W] = design_power_level_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avg_const_o <= AVG_RESET;
      core_limit_o <= PL_RESET;
      core_drop_allowed_o <= 1'b0;
      pkg_limit_o <= 64'h0;
      pkg_pl1_eff_o <= 15'h0;
      pkg_drop_allowed_o <= 1'b0;
    end else begin
      avg_const_o <= avg_q;
      core_limit_o <= core_q;
      core_drop_allowed_o <= core_q[PL_EN_BIT] & core_q[PL_CLAMP_BIT];
      pkg_limit_o <= {pkg_hi_q, pkg_lo_rd};
      // Disabled or uninitialised limit 1 still turbos to design power
      if (pl1_init_q && pkg_lo_q[PL_EN_BIT]) begin
        pkg_pl1_eff_o <= pkg_lo_q[PL_LIM_LSB +: PL_LIM_W];
      end else begin
        pkg_pl1_eff_o <= design_power_level_i;
      end
      pkg_drop_allowed_o <= (pkg_lo_q[PL_EN_BIT] & pkg_lo_q[PL_CLAMP_BIT]) |
                            (pkg_hi_q[PL_EN_BIT] & pkg_hi_q[PL_CLAMP_BIT]);
    end
  end

  // ==========================================================
  // Response, one cycle after the request
  logic [31:0] rd_data;
  logic rd_ok;
  always_comb begin
    rd_data = 32'h0;
    rd_ok = 1'b1;
    case (req_svc_i)
      TPS_SVC_THERM_STATUS: begin
        rd_data = ts_word;
        rd_ok = ~req_write_i & ts_ok;
      end
      TPS_SVC_AVG_CONST: begin
        rd_data = {28'h0, avg_q};
        rd_ok = ~req_write_i | avg_wr_ok;
      end
      TPS_SVC_TC_TIME: begin
        rd_data = cnt_val[CNT_TC];
        rd_ok = ~req_write_i;
      end
      TPS_SVC_CUR_LIMIT: begin
        rd_data = {19'h0, CUR_RESET};
        rd_ok = ~req_write_i;
      end
      TPS_SVC_ENERGY: begin
        if (req_param_i == ENERGY_SEL_PKG) begin
          rd_data = cnt_val[CNT_E_PKG];
        end else if (req_param_i == ENERGY_SEL_CORE) begin
          rd_data = cnt_val[CNT_E_CORE];
        end else begin
          rd_ok = 1'b0;
        end
        if (req_write_i) begin
          rd_ok = 1'b0;
        end
      end
      TPS_SVC_CORE_LIMIT: rd_data = core_q;
      TPS_SVC_PKG_LIM_LO: rd_data = pkg_lo_rd;
      TPS_SVC_PKG_LIM_HI: rd_data = pkg_hi_q;
      TPS_SVC_PERF_TIME: begin
        rd_data = cnt_val[CNT_PERF];
        rd_ok = ~req_write_i;
      end
      TPS_SVC_UNITS: begin
        rd_data = 32'h0;
        rd_data[UNIT_POWER_LSB +: 4] = UNIT_POWER;
        rd_data[UNIT_ENERGY_LSB +: 5] = UNIT_ENERGY;
        rd_data[UNIT_TIME_LSB +: 4] = UNIT_TIME;
        rd_ok = ~req_write_i;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsp_valid_o <= 1'b0;
      rsp_ok_o <= 1'b0;
      rsp_data_o <= 32'h0;
    end else begin
      rsp_valid_o <= req_valid_i;
      if (req_valid_i) begin
        rsp_ok_o <= rd_ok;
        rsp_data_o <= req_write_i ? 32'h0 : rd_data;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  chk_log_sets: assert property (tcc_active_i && !stat_q[0] |=> log_q[0])
    else $error("activation log not set on rising edge");
  chk_log_holds: assert property (log_q[1] && !ts_rd |=> log_q[1])
    else $error("throttle log lost without a clearing read");
  chk_mask_clear: assert property (ts_ok && !req_wdata_i[TS_TCC_LOG] && !rise[0]
    && req_wdata_i[TS_PIN_LOG] && log_q[1] |=> !log_q[0] && log_q[1])
    else $error("mask clear wrong");
  chk_bad_mask: assert property (ts_rd && mask_illegal(req_wdata_i)
    |=> rsp_valid_o && !rsp_ok_o && (log_q == ($past(log_q) | $past(rise))))
    else $error("illegal mask not refused");
  chk_avg_range: assert property (avg_q <= AVG_MAX)
    else $error("averaging constant above maximum");
  chk_ext_hold: assert property (ms_tick && tcc_ext_pin_i && !tcc_ramp_i
    |=> $stable(cnt_val[CNT_TC]))
    else $error("constrained time advanced on external pin");
  chk_core_enable: assert property (!core_q[PL_EN_BIT] |=> !core_drop_allowed_o)
    else $error("core drop allowed while limit disabled");
  chk_pl1_default: assert property (!pl1_init_q |=>
    pkg_pl1_eff_o == $past(design_power_level_i))
    else $error("limit 1 not at design power level");
  chk_rsp_timing: assert property (rsp_valid_o == $past(req_valid_i))
    else $error("answer not one cycle after request");
  chk_same_cycle: assert property (ts_ok && rise[0] |=> log_q[0])
    else $error("same-cycle rise lost to clear");

  cov_clear_tcc: cover property (ts_ok && req_wdata_i == TS_MASK_TCC_ONLY && log_q[0]);
  cov_bad_mask: cover property (ts_rd && mask_illegal(req_wdata_i));
  cov_pkg_write: cover property (wr_req && req_svc_i == TPS_SVC_PKG_LIM_HI);
  cov_core_clamp: cover property (core_drop_allowed_o);

endmodule : tps_regs
`default_nettype wire

// *** core/tps_tick.sv ***
// Free-running divider giving a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module tps_tick #(
  parameter int unsigned DIV = 50000
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  output logic tick_o
);
  logic [31:0] cnt_q;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= 32'h0;
      tick_o <= 1'b0;
    end else if (cnt_q == DIV - 1) begin
      cnt_q <= 32'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
      tick_o <= 1'b0;
    end
  end
endmodule : tps_tick
`default_nettype wire

// *** core/tps_wrap_cnt.sv ***
// 32-bit accumulating counter that wraps on overflow
`timescale 1ns/1ps
`default_nettype none
module tps_wrap_cnt (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic en_i,
  input wire logic [15:0] inc_i,
  output logic [31:0] cnt_o
);
  // Plain modulo add: overflow simply wraps
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_o <= 32'h0;
    end else if (en_i) begin
      cnt_o <= cnt_o + {16'h0, inc_i};
    end
  end
endmodule : tps_wrap_cnt
`default_nettype wire

// *** dv/tps_host_model.sv ***
// Sideband host model issuing one request at a time to the register bank
`timescale 1ns/1ps
`default_nettype none
module tps_host_model (
  input wire logic clk_sys_i,
  output logic req_valid_o,
  output logic req_write_o,
  output tps_pkg::tps_svc_t req_svc_o,
  output logic [15:0] req_param_o,
  output logic [31:0] req_wdata_o,
  input wire logic rsp_valid_i,
  input wire logic rsp_ok_i,
  input wire logic [31:0] rsp_data_i
);
  import tps_pkg::*;

  initial begin
    req_valid_o = 1'b0;
    req_write_o = 1'b0;
    req_svc_o = TPS_SVC_THERM_STATUS;
    req_param_o = 16'h0000;
    req_wdata_o = 32'h0000_0000;
  end

  // ==========================================================
  // One request; the answer is awaited for a bounded number of edges
  task automatic xfer(input logic wr, input tps_svc_t svc, input logic [15:0] prm,
                      input logic [31:0] wd, output logic got, output logic ok,
                      output logic [31:0] rd);
    got = 1'b0;
    ok = 1'b0;
    rd = 32'h0000_0000;
    @(posedge clk_sys_i);
    #1;
    req_valid_o = 1'b1;
    req_write_o = wr;
    req_svc_o = svc;
    req_param_o = prm;
    req_wdata_o = wd;
    @(posedge clk_sys_i);
    #1;
    req_valid_o = 1'b0;
    // Released data carries junk so a late sample cannot pass by luck
    req_wdata_o = ~wd;
    req_param_o = ~prm;
    for (int i = 0; i < 4 && !got; i++) begin
      if (rsp_valid_i === 1'b1) begin
        got = 1'b1;
        ok = rsp_ok_i;
        rd = rsp_data_i;
      end else begin
        @(posedge clk_sys_i);
        #1;
      end
    end
  endtask : xfer
endmodule : tps_host_model
`default_nettype wire

// *** dv/tps_regs_tb.sv ***
// Self-checking testbench of the thermal and power service register bank
`timescale 1ns/1ps
`default_nettype none
module tps_regs_tb;
  import tps_pkg::*;
  localparam logic [14:0] DPL = 15'h0123;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic req_valid_i, req_write_i, rsp_valid_o, rsp_ok_o;
  tps_svc_t req_svc_i;
  logic [15:0] req_param_i;
  logic [31:0] req_wdata_i, rsp_data_o, core_limit_o;
  logic tcc_active_i, tcc_ext_pin_i, tcc_ramp_i, throttle_pin_i, crit_temp_i, below_os_req_i;
  logic [15:0] energy_pkg_inc_i = 16'h0003;
  logic [15:0] energy_core_inc_i = 16'h0005;
  logic [14:0] design_power_level_i = DPL;
  logic [3:0] avg_const_o;
  logic core_drop_allowed_o, pkg_drop_allowed_o;
  logic [63:0] pkg_limit_o;
  logic [14:0] pkg_pl1_eff_o;
  int mismatches = 0;
  int n_compared = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  tps_regs #(.MS_CYC(10), .TU_CYC(7)) tps_regs_inst (.clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_svc_i(req_svc_i), .req_param_i(req_param_i), .req_wdata_i(req_wdata_i),
    .rsp_valid_o(rsp_valid_o), .rsp_ok_o(rsp_ok_o), .rsp_data_o(rsp_data_o),
    .tcc_active_i(tcc_active_i), .tcc_ext_pin_i(tcc_ext_pin_i), .tcc_ramp_i(tcc_ramp_i),
    .throttle_pin_i(throttle_pin_i), .crit_temp_i(crit_temp_i),
    .below_os_req_i(below_os_req_i), .energy_pkg_inc_i(energy_pkg_inc_i),
    .energy_core_inc_i(energy_core_inc_i), .design_power_level_i(design_power_level_i),
    .avg_const_o(avg_const_o), .core_limit_o(core_limit_o),
    .core_drop_allowed_o(core_drop_allowed_o), .pkg_limit_o(pkg_limit_o),
    .pkg_pl1_eff_o(pkg_pl1_eff_o), .pkg_drop_allowed_o(pkg_drop_allowed_o));

  tps_host_model tps_host_model_inst (.clk_sys_i(clk_sys_i), .req_valid_o(req_valid_i),
    .req_write_o(req_write_i), .req_svc_o(req_svc_i), .req_param_o(req_param_i),
    .req_wdata_o(req_wdata_i), .rsp_valid_i(rsp_valid_o), .rsp_ok_i(rsp_ok_o),
    .rsp_data_i(rsp_data_o));

  // ==========================================================
  // Shared helpers
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : cyc

  task automatic req(input logic wr, input tps_svc_t svc, input logic [15:0] prm,
                     input logic [31:0] wd, output logic ok, output logic [31:0] rd);
    logic got;
    tps_host_model_inst.xfer(wr, svc, prm, wd, got, ok, rd);
    if (got !== 1'b1) begin
      mismatches++;
      $display("[FAIL] %0t no answer to request", $time);
      print_verdict();
    end
  endtask : req

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic ok;
    logic [31:0] rd;
    // Output flops take their first values on the edges after release
    cyc(2);
    check(32'(avg_const_o), 32'h4, "averaging reset");
    check(core_limit_o, 32'h0, "core limit reset");
    check(32'(core_drop_allowed_o), 32'h0, "core drop reset");
    check(32'(pkg_pl1_eff_o), 32'(DPL), "limit 1 default");
    check(pkg_limit_o[63:32], 32'h0, "limit 2 no default");
    req(1'b0, TPS_SVC_PKG_LIM_LO, 16'h0, 32'h0, ok, rd);
    check(rd, 32'(DPL), "limit 1 readback default");
    req(1'b0, TPS_SVC_UNITS, 16'h0, 32'h0, ok, rd);
    check(rd, 32'h000a_1003, "unit word");
    req(1'b0, TPS_SVC_CUR_LIMIT, 16'h0, 32'h0, ok, rd);
    check(rd, 32'h0000_0438, "current limit");
    req(1'b1, TPS_SVC_CUR_LIMIT, 16'h0, 32'h1, ok, rd);
    check(32'(ok), 32'h0, "read-only write refused");
    $display("test reset values done");
  endtask : t_reset

  task automatic t_logs;
    logic ok;
    logic [31:0] rd;
    {tcc_active_i, throttle_pin_i, crit_temp_i} = 3'b111;
    cyc(1);
    {tcc_active_i, throttle_pin_i, crit_temp_i} = 3'b000;
    cyc(20);
    req(1'b0, TPS_SVC_THERM_STATUS, 16'h0, 32'hffff_ffff, ok, rd);
    check(rd, 32'h0000_002a, "logs set and kept");
    req(1'b0, TPS_SVC_THERM_STATUS, 16'h0, 32'hffff_fffe, ok, rd);
    check(32'(ok), 32'h0, "illegal mask refused");
    req(1'b0, TPS_SVC_THERM_STATUS, 16'h0, 32'hffff_fffd, ok, rd);
    check(rd, 32'h0000_002a, "pre-clear word");
    req(1'b0, TPS_SVC_THERM_STATUS, 16'h0, 32'hffff_ffd7, ok, rd);
    check(rd, 32'h0000_0028, "only activation log cleared");
    // Activation rises on the very edge that takes a clearing read
    fork
      req(1'b0, TPS_SVC_THERM_STATUS, 16'h0, TS_MASK_TCC_ONLY, ok, rd);
      begin
        cyc(1);
        tcc_active_i = 1'b1;
      end
    join
    check(rd, 32'h0000_0000, "logs before rise");
    tcc_active_i = 1'b0;
    req(1'b0, TPS_SVC_THERM_STATUS, 16'h0, TS_MASK_TCC_ONLY, ok, rd);
    check(rd, 32'h0000_0002, "same-cycle rise kept");
    req(1'b0, TPS_SVC_THERM_STATUS, 16'h0, 32'hffff_ffff, ok, rd);
    check(rd, 32'h0000_0000, "masked logs cleared");
    $display("test thermal logs done");
  endtask : t_logs

  task automatic t_avg;
    logic ok;
    logic [31:0] rd;
    req(1'b1, TPS_SVC_AVG_CONST, 16'h0, 32'h8, ok, rd);
    cyc(1);
    check(32'(avg_const_o), 32'h8, "maximum accepted");
    req(1'b1, TPS_SVC_AVG_CONST, 16'h0, 32'h9, ok, rd);
    cyc(1);
    check({31'h0, ok}, 32'h0, "above maximum refused");
    check(32'(avg_const_o), 32'h8, "refused value not stored");
    req(1'b1, TPS_SVC_AVG_CONST, 16'h0, 32'h0, ok, rd);
    req(1'b0, TPS_SVC_AVG_CONST, 16'h0, 32'h0, ok, rd);
    check(rd, 32'h0, "averaging off");
    $display("test averaging constant done");
  endtask : t_avg

  task automatic t_core;
    logic ok;
    logic [31:0] rd;
    // Each write carries every field, even when one changes
    req(1'b1, TPS_SVC_CORE_LIMIT, 16'h0, {8'h00, 7'h2a, 1'b1, 1'b1, 15'h0100}, ok, rd);
    cyc(1);
    check(32'(core_limit_o[23:17]), 32'h2a, "window field");
    check(32'(core_drop_allowed_o), 32'h1, "enable and clamp");
    req(1'b1, TPS_SVC_CORE_LIMIT, 16'h0, {8'h00, 7'h2a, 1'b0, 1'b1, 15'h0100}, ok, rd);
    cyc(1);
    check(32'(core_drop_allowed_o), 32'h0, "clamp off");
    req(1'b1, TPS_SVC_CORE_LIMIT, 16'h0, {8'h00, 7'h2a, 1'b1, 1'b0, 15'h0100}, ok, rd);
    cyc(1);
    check(32'(core_drop_allowed_o), 32'h0, "enable off");
    $display("test core limit done");
  endtask : t_core

  task automatic t_pkg;
    logic ok;
    logic [31:0] rd;
    logic [31:0] lo;
    logic [31:0] hi;
    lo = {8'h00, 7'h0e, 1'b1, 1'b1, 15'h0050};
    // Limit 2 about a fifth above limit 1, window 2 of 5 ms
    hi = {8'h00, 7'h05, 1'b0, 1'b1, 15'h0060};
    req(1'b1, TPS_SVC_PKG_LIM_HI, 16'h0, hi, ok, rd);
    cyc(1);
    check(32'(pkg_pl1_eff_o), 32'(DPL), "turbo to design level");
    check(32'(pkg_limit_o[14:0]), 32'(DPL), "low word untouched");
    req(1'b1, TPS_SVC_PKG_LIM_LO, 16'h0, lo, ok, rd);
    cyc(1);
    check(pkg_limit_o[31:0], lo, "low half");
    check(pkg_limit_o[63:32], hi, "high half");
    check(32'(pkg_limit_o[55:49]), 32'h5, "window 2 in ms");
    check(32'(pkg_pl1_eff_o), 32'h50, "limit 1 applied");
    check(32'(pkg_drop_allowed_o), 32'h1, "package clamp");
    $display("test package limits done");
  endtask : t_pkg

  task automatic t_counters;
    logic ok;
    logic [31:0] a;
    logic [31:0] b;
    req(1'b0, TPS_SVC_TC_TIME, 16'h0, 32'h0, ok, a);
    tcc_active_i = 1'b1;
    cyc(100);
    tcc_active_i = 1'b0;
    cyc(3);
    req(1'b0, TPS_SVC_TC_TIME, 16'h0, 32'h0, ok, b);
    check(32'((b - a) >= 9 && (b - a) <= 11), 32'h1, "constrained time");
    tcc_ramp_i = 1'b1;
    cyc(50);
    tcc_ramp_i = 1'b0;
    req(1'b0, TPS_SVC_TC_TIME, 16'h0, 32'h0, ok, a);
    check(32'((a - b) >= 4 && (a - b) <= 6), 32'h1, "ramp counted");
    {tcc_active_i, tcc_ext_pin_i} = 2'b11;
    cyc(100);
    {tcc_active_i, tcc_ext_pin_i} = 2'b00;
    cyc(3);
    req(1'b0, TPS_SVC_TC_TIME, 16'h0, 32'h0, ok, b);
    check(b - a, 32'h0, "pin activation ignored");
    // Deltas taken modulo 2^32 so a wrap costs nothing
    req(1'b0, TPS_SVC_ENERGY, ENERGY_SEL_PKG, 32'h0, ok, a);
    req(1'b0, TPS_SVC_ENERGY, ENERGY_SEL_PKG, 32'h0, ok, b);
    check(b - a, 32'h6, "package energy");
    req(1'b0, TPS_SVC_ENERGY, ENERGY_SEL_CORE, 32'h0, ok, a);
    req(1'b0, TPS_SVC_ENERGY, ENERGY_SEL_CORE, 32'h0, ok, b);
    check(b - a, 32'ha, "core energy");
    req(1'b0, TPS_SVC_ENERGY, 16'h0002, 32'h0, ok, a);
    check({31'h0, ok}, 32'h0, "bad energy select");
    req(1'b0, TPS_SVC_PERF_TIME, 16'h0, 32'h0, ok, a);
    below_os_req_i = 1'b1;
    cyc(70);
    below_os_req_i = 1'b0;
    req(1'b0, TPS_SVC_PERF_TIME, 16'h0, 32'h0, ok, b);
    check(32'((b - a) >= 9 && (b - a) <= 11), 32'h1, "below request time");
    $display("test counters done");
  endtask : t_counters

  task automatic t_rereset;
    logic ok;
    logic [31:0] rd;
    crit_temp_i = 1'b1;
    cyc(3);
    crit_temp_i = 1'b0;
    resetn_i = 1'b0;
    cyc(2);
    resetn_i = 1'b1;
    req(1'b0, TPS_SVC_THERM_STATUS, 16'h0, 32'hffff_ffff, ok, rd);
    check(rd, 32'h0, "reset clears logs");
    check(32'(avg_const_o), 32'h4, "averaging back to reset");
    $display("test mid-run reset done");
  endtask : t_rereset

  initial begin
    {tcc_active_i, tcc_ext_pin_i, tcc_ramp_i} = 3'b000;
    {throttle_pin_i, crit_temp_i, below_os_req_i} = 3'b000;
    repeat (10) @(posedge clk_sys_i);
    #1;
    resetn_i = 1'b1;
    t_reset();
    t_logs();
    t_avg();
    t_core();
    t_pkg();
    t_counters();
    t_rereset();
    print_verdict();
  end
endmodule : tps_regs_tb
`default_nettype wire

// *** inc/tps_pkg.sv ***
// Constants and types for the thermal and power service register bank
package tps_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_TICK_CYC = CLK_HZ / MS_PER_S;
  localparam int unsigned TIME_UNIT_DIV = 1024;
  localparam int unsigned TU_TICK_CYC = CLK_HZ / TIME_UNIT_DIV;

  // ==========================================================
  // Service codes of the request port
  typedef enum logic [3:0] {
    TPS_SVC_THERM_STATUS = 4'h0,
    TPS_SVC_AVG_CONST    = 4'h1,
    TPS_SVC_TC_TIME      = 4'h2,
    TPS_SVC_CUR_LIMIT    = 4'h3,
    TPS_SVC_ENERGY       = 4'h4,
    TPS_SVC_CORE_LIMIT   = 4'h5,
    TPS_SVC_PKG_LIM_LO   = 4'h6,
    TPS_SVC_PKG_LIM_HI   = 4'h7,
    TPS_SVC_PERF_TIME    = 4'h8,
    TPS_SVC_UNITS        = 4'h9
  } tps_svc_t;

  // ==========================================================
  // Thermal status word
  localparam int unsigned TS_TCC_STAT = 0;
  localparam int unsigned TS_TCC_LOG = 1;
  localparam int unsigned TS_PIN_STAT = 2;
  localparam int unsigned TS_PIN_LOG = 3;
  localparam int unsigned TS_CRIT_STAT = 4;
  localparam int unsigned TS_CRIT_LOG = 5;
  localparam logic [31:0] TS_LOG_BITS = 32'h0000_002a;
  localparam logic [31:0] TS_MASK_TCC_ONLY = 32'hffff_fffd;

  // ==========================================================
  // Averaging constant
  localparam logic [3:0] AVG_RESET = 4'h4;
  localparam logic [3:0] AVG_MAX = 4'h8;

  // ==========================================================
  // Current limit readback
  localparam int unsigned CUR_W = 13;
  localparam logic [12:0] CUR_RESET = 13'h0438;

  // ==========================================================
  // Power limit word fields (same layout in both halves)
  localparam int unsigned PL_LIM_LSB = 0;
  localparam int unsigned PL_LIM_W = 15;
  localparam int unsigned PL_EN_BIT = 15;
  localparam int unsigned PL_CLAMP_BIT = 16;
  localparam int unsigned PL_WIN_LSB = 17;
  localparam int unsigned PL_WIN_W = 7;
  localparam logic [31:0] PL_RESET = 32'h0000_0000;

  // ==========================================================
  // Unit word
  localparam logic [3:0] UNIT_POWER = 4'h3;
  localparam logic [4:0] UNIT_ENERGY = 5'h10;
  localparam logic [3:0] UNIT_TIME = 4'ha;
  localparam int unsigned UNIT_POWER_LSB = 0;
  localparam int unsigned UNIT_ENERGY_LSB = 8;
  localparam int unsigned UNIT_TIME_LSB = 16;

  // ==========================================================
  // Counter bank indices
  localparam int unsigned CNT_N = 4;
  localparam int unsigned CNT_TC = 0;
  localparam int unsigned CNT_PERF = 1;
  localparam int unsigned CNT_E_PKG = 2;
  localparam int unsigned CNT_E_CORE = 3;
  localparam logic [15:0] ENERGY_SEL_PKG = 16'h0000;
  localparam logic [15:0] ENERGY_SEL_CORE = 16'h0001;

endpackage : tps_pkg
